// ---- hw/fpet_cfg.svh ----
`ifndef FPET_CFG_SVH
`define FPET_CFG_SVH

// ------------------------------------------------------------
// Clock and timing figures
// ------------------------------------------------------------
`define FPET_CLK_MHZ        10
`define FPET_PGM_PULSE_US   100
`define FPET_ERS_PULSE_US   7000
`define FPET_FLW_PULSE_US   14000
`define FPET_SETTLE_US      10
`define FPET_PGM_PULSE_CYC  (`FPET_PGM_PULSE_US * `FPET_CLK_MHZ)
`define FPET_ERS_PULSE_CYC  (`FPET_ERS_PULSE_US * `FPET_CLK_MHZ)
`define FPET_FLW_PULSE_CYC  (`FPET_FLW_PULSE_US * `FPET_CLK_MHZ)
`define FPET_SETTLE_CYC     (`FPET_SETTLE_US * `FPET_CLK_MHZ)

// ------------------------------------------------------------
// Pulse-count limits
// ------------------------------------------------------------
`define FPET_PGM_MAX_PULSES 150
`define FPET_ERS_MAX_PULSES 1000
`define FPET_FLW_MAX_PULSES 6000
`define FPET_CNT_W          18
`define FPET_PLS_W          13

`endif

// ---- hw/fpet_pkg.sv ----
`default_nettype none
package fpet_pkg;

    typedef enum logic [1:0] {
        FPET_OP_PGM = 2'b00,
        FPET_OP_ERS = 2'b01,
        FPET_OP_FLW = 2'b10
    } fpet_op_type;

    typedef enum logic [2:0] {
        FPET_ST_IDLE   = 3'b000,
        FPET_ST_SETUP  = 3'b001,
        FPET_ST_PULSE  = 3'b010,
        FPET_ST_DESEL  = 3'b011,
        FPET_ST_VSET   = 3'b100,
        FPET_ST_VCHK   = 3'b101,
        FPET_ST_FINISH = 3'b110
    } fpet_state_type;

endpackage
`default_nettype wire

// ---- hw/fpet_tmr_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Timer load and expiry between sequencer and down-counter
// ------------------------------------------------------------
interface fpet_tmr_if;
    logic        load;
    logic [17:0] count;
    logic        done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

`default_nettype wire

// ---- hw/fpet_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Down-counter, done is high once the loaded count has elapsed
// ------------------------------------------------------------
module fpet_timer (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    // Timer port
    fpet_tmr_if.tmr   tmr
);
    logic [17:0] cnt_q;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 18'h00000;
        end else if (tmr.load) begin
            cnt_q <= tmr.count;
        end else if (cnt_q != 18'h00000) begin
            cnt_q <= cnt_q - 18'h00001;
        end
    end

    // Done looks only at the count, because the load is decoded from done and would loop.
    assign tmr.done = (cnt_q == 18'h00000);
endmodule

`default_nettype wire

// ---- hw/fpet_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpet_cfg.svh"

module fpet_seq
    import fpet_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // Command from the algorithm owner
    input  wire logic        i_start,
    input  wire logic [1:0]  i_op,
    // Verify result from the array compare
    input  wire logic        i_verify_ok,
    // Array mode and pulse controls
    output logic             o_pgm_mode,
    output logic             o_ers_mode,
    output logic             o_flw_mode,
    output logic             o_verify_mode,
    output logic             o_pulse,
    output logic             o_sample,
    // Status
    output logic             o_busy,
    output logic             o_done,
    output logic             o_fail,
    output logic [12:0]      o_pulse_count
);
    fpet_tmr_if     tmr_bus ();
    fpet_state_type state_q;
    fpet_op_type    op_q;
    logic [12:0]    pulses_q;
    logic [12:0]    limit;
    logic [17:0]    width;
    logic           last_verify_q;
    logic           desel_hold_q;

    // ------------------------------------------------------------
    // Shared wait timer
    // ------------------------------------------------------------
    fpet_timer u_timer (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .tmr       (tmr_bus.tmr)
    );

    // ------------------------------------------------------------
    // Per-operation pulse width and pulse limit
    // ------------------------------------------------------------
    always_comb begin
        case (op_q)
            FPET_OP_PGM: begin
                width = 18'(`FPET_PGM_PULSE_CYC);
                limit = 13'(`FPET_PGM_MAX_PULSES);
            end
            FPET_OP_ERS: begin
                width = 18'(`FPET_ERS_PULSE_CYC);
                limit = 13'(`FPET_ERS_MAX_PULSES);
            end
            default: begin
                width = 18'(`FPET_FLW_PULSE_CYC);
                limit = 13'(`FPET_FLW_MAX_PULSES);
            end
        endcase
    end

    // ------------------------------------------------------------
    // Timer loads on every state entry that needs a wait
    // ------------------------------------------------------------
    always_comb begin
        tmr_bus.load  = 1'b0;
        tmr_bus.count = 18'(`FPET_SETTLE_CYC);
        case (state_q)
            FPET_ST_IDLE: begin
                tmr_bus.load = i_start && !desel_hold_q;
            end
            FPET_ST_SETUP: begin
                tmr_bus.load  = tmr_bus.done;
                tmr_bus.count = width;
            end
            FPET_ST_PULSE,
            FPET_ST_DESEL: begin
                tmr_bus.load = tmr_bus.done;
            end
            FPET_ST_VCHK: begin
                tmr_bus.load = 1'b1;
            end
            default: begin
                tmr_bus.load = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q       <= FPET_ST_IDLE;
            op_q          <= FPET_OP_PGM;
            pulses_q      <= 13'h0000;
            last_verify_q <= 1'b0;
        end else begin
            case (state_q)
                FPET_ST_IDLE: begin
                    if (i_start && !desel_hold_q) begin
                        op_q     <= (i_op == 2'h3) ? FPET_OP_FLW : fpet_op_type'(i_op);
                        pulses_q <= 13'h0000;
                        state_q  <= FPET_ST_SETUP;
                    end
                end
                FPET_ST_SETUP: begin
                    if (tmr_bus.done) begin
                        pulses_q <= pulses_q + 13'h0001;
                        state_q  <= FPET_ST_PULSE;
                    end
                end
                FPET_ST_PULSE: begin
                    if (tmr_bus.done) begin
                        state_q <= FPET_ST_DESEL;
                    end
                end
                FPET_ST_DESEL: begin
                    if (tmr_bus.done) begin
                        state_q <= FPET_ST_VSET;
                    end
                end
                FPET_ST_VSET: begin
                    if (tmr_bus.done) begin
                        state_q <= FPET_ST_VCHK;
                    end
                end
                FPET_ST_VCHK: begin
                    last_verify_q <= i_verify_ok;
                    if (i_verify_ok || pulses_q >= limit) begin
                        state_q <= FPET_ST_FINISH;
                    end else begin
                        state_q <= FPET_ST_SETUP;
                    end
                end
                FPET_ST_FINISH: begin
                    state_q <= FPET_ST_IDLE;
                end
                default: begin
                    state_q <= FPET_ST_IDLE;
                end
            endcase
        end
    end

    // The verify exit also needs a deselect gap before a new command.
    // gap before next start
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            desel_hold_q <= 1'b0;
        end else if (state_q == FPET_ST_VCHK) begin
            desel_hold_q <= 1'b1;
        end else if (state_q == FPET_ST_IDLE && tmr_bus.done) begin
            desel_hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered array controls and status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pgm_mode    <= 1'b0;
            o_ers_mode    <= 1'b0;
            o_flw_mode    <= 1'b0;
            o_verify_mode <= 1'b0;
            o_pulse       <= 1'b0;
            o_sample      <= 1'b0;
            o_busy        <= 1'b0;
            o_done        <= 1'b0;
            o_fail        <= 1'b0;
            o_pulse_count <= 13'h0000;
        end else begin
            o_pgm_mode    <= (state_q == FPET_ST_SETUP || state_q == FPET_ST_PULSE)
                             && op_q == FPET_OP_PGM;
            o_ers_mode    <= (state_q == FPET_ST_SETUP || state_q == FPET_ST_PULSE)
                             && op_q == FPET_OP_ERS;
            o_flw_mode    <= (state_q == FPET_ST_SETUP || state_q == FPET_ST_PULSE)
                             && op_q == FPET_OP_FLW;
            o_verify_mode <= state_q == FPET_ST_VSET || state_q == FPET_ST_VCHK;
            o_pulse       <= state_q == FPET_ST_PULSE;
            o_sample      <= state_q == FPET_ST_VCHK;
            o_busy        <= state_q != FPET_ST_IDLE || desel_hold_q;
            o_done        <= state_q == FPET_ST_FINISH;
            o_fail        <= state_q == FPET_ST_FINISH && !last_verify_q;
            o_pulse_count <= pulses_q;
        end
    end
endmodule

`default_nettype wire

// ---- test/fpet_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpet_chk (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        o_pgm_mode,
    input wire logic        o_ers_mode,
    input wire logic        o_flw_mode,
    input wire logic        o_verify_mode,
    input wire logic        o_pulse,
    input wire logic        o_sample,
    input wire logic        o_done,
    input wire logic        o_fail,
    input wire logic [12:0] o_pulse_count
);
    logic [17:0] w_q;
    logic [7:0]  a_q;
    logic [7:0]  g_q;
    logic [7:0]  v_q;
    wire  logic  m = o_pgm_mode | o_ers_mode | o_flw_mode;
    // The a_q, g_q and v_q counters saturate so a long idle spell cannot wrap into a false short gap.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        w_q <= i_sys_rst ? 18'h0 : (o_pulse ? w_q + 18'h1 : 18'h0);
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        a_q <= (i_sys_rst || !m) ? 8'h0 : a_q + {7'h0, ~&a_q};
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        g_q <= i_sys_rst ? 8'hff : (m ? 8'h0 : g_q + {7'h0, ~&g_q});
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        v_q <= (i_sys_rst || m) ? 8'h0 : v_q + {7'h0, o_verify_mode & ~&v_q};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    sequence pulse_end;
        $fell(o_pulse);
    endsequence
    chk_mode_settle: assert property ($rose(o_pulse) |-> a_q >= 8'h64)
        else $error("pulse began before mode settled");
    chk_pgm_width: assert property (pulse_end ##0 $past(o_pgm_mode) |->
        w_q inside {[18'h3b6:18'h41a]}) else $error("program pulse width wrong");
    chk_ers_width: assert property (pulse_end ##0 $past(o_ers_mode) |->
        w_q inside {[18'h103c4:18'h11f1c]}) else $error("erase pulse width wrong");
    chk_flw_width: assert property (pulse_end ##0 $past(o_flw_mode) |->
        w_q inside {[18'h20788:18'h23e38]}) else $error("flash-write pulse width wrong");
    chk_desel_gap: assert property ($rose(o_verify_mode) || $rose(m) |-> g_q >= 8'h64)
        else $error("deselect gap too short");
    chk_verify_settle: assert property (o_sample |-> v_q >= 8'h64)
        else $error("sampled before verify settled");
    chk_pgm_limit: assert property (o_pgm_mode |-> o_pulse_count <= 13'h96)
        else $error("program pulse limit passed");
    chk_ers_limit: assert property (o_ers_mode |-> o_pulse_count <= 13'h3e8)
        else $error("erase pulse limit passed");
    chk_flw_limit: assert property (o_flw_mode |-> o_pulse_count <= 13'h1770)
        else $error("flash-write pulse limit passed");
    chk_fail_done: assert property (o_fail |-> o_done)
        else $error("fail without done");
    chk_pulse_mode: assert property (o_pulse |-> m)
        else $error("pulse with no mode selected");
endmodule
bind fpet_seq fpet_chk chk_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .o_pgm_mode(o_pgm_mode), .o_ers_mode(o_ers_mode), .o_flw_mode(o_flw_mode),
    .o_verify_mode(o_verify_mode), .o_pulse(o_pulse), .o_sample(o_sample),
    .o_done(o_done), .o_fail(o_fail), .o_pulse_count(o_pulse_count));
`default_nettype wire

// ---- test/fpet_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpet_array_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_mode,
    input  wire logic        i_pulse,
    input  wire logic        i_sample,
    input  wire logic [12:0] i_need,
    output logic             o_verify_ok,
    output logic [7:0]       o_viol
);
    logic [17:0] w_q;
    logic [7:0]  a_q;
    logic [7:0]  g_q;
    logic [7:0]  v_q;
    logic [12:0] n_q;
    logic [3:0]  r_q;
    logic        p_q;
    logic        t_q;
    logic        bad;
    wire  logic  m = |i_mode[2:0];
    wire  logic  rise = i_pulse & ~p_q;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        w_q <= i_sys_rst ? 18'h0 : (i_pulse ? w_q + 18'h1 : 18'h0);
        a_q <= (i_sys_rst || !m) ? 8'h0 : a_q + {7'h0, ~&a_q};
        g_q <= i_sys_rst ? 8'hff : (m ? 8'h0 : g_q + {7'h0, ~&g_q});
        v_q <= (i_sys_rst || m) ? 8'h0 : v_q + {7'h0, i_mode[3] & ~&v_q};
        n_q <= (i_sys_rst || (i_sample && o_verify_ok)) ? 13'h0 : n_q + {12'h0, rise};
        r_q <= i_sys_rst ? 4'h0 : i_mode;
        p_q <= i_sys_rst ? 1'b0 : i_pulse;
        t_q <= i_sys_rst ? 1'b0 : ~t_q;
        o_viol <= i_sys_rst ? 8'h0 : o_viol + {7'h0, bad};
    end
    // The compare is unreliable until verify-read has settled.
    assign o_verify_ok = (v_q >= 8'h64) ? (n_q >= i_need) : t_q;
    always_comb begin
        bad = 1'b0;
        if (rise && a_q < 8'h64)
            bad = 1'b1;
        if ((i_mode & ~r_q) != 4'h0 && g_q < 8'h64)
            bad = 1'b1;
        if (i_sample && v_q < 8'h64)
            bad = 1'b1;
        if (!i_pulse && p_q)
            bad = bad | (r_q[0] ? (w_q < 18'h3b6 || w_q > 18'h41a) : r_q[1] ?
                (w_q < 18'h103c4 || w_q > 18'h11f1c) : (w_q < 18'h20788 || w_q > 18'h23e38));
        if (rise)
            bad = bad | (n_q >= (i_mode[0] ? 13'h96 : i_mode[1] ? 13'h3e8 : 13'h1770));
    end
endmodule
`default_nettype wire

// ---- test/flash_program_erase_timing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_timing_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [1:0]  op = 2'h0;
    logic [12:0] need = 13'h1;
    logic        ok, pgm, ers, flw, ver, pulse, smp, busy, done, fail;
    logic [12:0] cnt;
    logic [7:0]  viol;
    int          bad_count = 0;
    int          n_tests = 0;
    always #50 clk = ~clk;
    fpet_seq dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_start(start), .i_op(op),
        .i_verify_ok(ok), .o_pgm_mode(pgm), .o_ers_mode(ers), .o_flw_mode(flw),
        .o_verify_mode(ver), .o_pulse(pulse), .o_sample(smp), .o_busy(busy),
        .o_done(done), .o_fail(fail), .o_pulse_count(cnt));
    fpet_array_model arr_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_mode({ver, flw, ers, pgm}),
        .i_pulse(pulse), .i_sample(smp), .i_need(need), .o_verify_ok(ok), .o_viol(viol));
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Flash-write runs 140000 cycles a pulse, too long for this run; its first pulse is only begun, then cut by reset.
    task automatic run_op(input string name, input logic [1:0] k, input logic [12:0] n,
                          input logic poke);
        int  i;
        logic hit;
        hit = 1'b0;
        need <= n;
        op <= k;
        start <= 1'b1;
        for (i = 0; i < 10 && busy !== 1'b1; i++)
            @(posedge clk);
        start <= 1'b0;
        if (poke) begin
            @(posedge clk);
            op <= 2'h1;
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
        end
        for (i = 0; i < 80000 && done !== 1'b1; i++) begin
            @(posedge clk);
            hit = hit | (ers === 1'b1);
        end
        check("done", done, 18'h1);
        check("fail", fail, 18'h0);
        check("count", cnt, n);
        check("erase seen", hit, k == 2'h1);
        for (i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clk);
        check("violations", viol, 18'h0);
        $display("test %s done", name);
    endtask
    // Flash-write is cut by a mid-run reset once its first pulse has begun.
    task automatic test_flw_reset(input string name, input logic [1:0] k);
        int i;
        op <= k;
        start <= 1'b1;
        for (i = 0; i < 10 && busy !== 1'b1; i++)
            @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < 300 && pulse !== 1'b1; i++)
            @(posedge clk);
        check("flw pulse", pulse, 18'h1);
        check("flw modes", {14'h0, ver, flw, ers, pgm}, 18'h4);
        check("flw count", cnt, 18'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check("reset pulse", pulse, 18'h0);
        check("reset busy", busy, 18'h0);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("release modes", {14'h0, ver, flw, ers, pgm}, 18'h0);
        check("release busy", busy, 18'h0);
        $display("test %s done", name);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        run_op("program single", 2'h0, 13'h1, 1'b0);
        run_op("program retry", 2'h0, 13'h3, 1'b1);
        run_op("erase", 2'h1, 13'h1, 1'b0);
        test_flw_reset("flash-write cut", 2'h2);
        test_flw_reset("code three cut", 2'h3);
        run_op("program after reset", 2'h0, 13'h1, 1'b0);
        test_done;
    end
    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        test_done;
    end
endmodule
`default_nettype wire
